/* File: rtl/ectm_top.sv */
// Function
// - only the first counter instance accepts configuration.
// - counted source is off, frame, row, exposure, link trigger or external.
// - count on rising or falling edge as selected.
// - clear source is off, frame, exposure, acquisition or external.
// - edge clear modes clear on rising, falling or either edge.
// - level clear modes hold the count cleared while high or low.
// - software clear zeroes the counter and resumes counting at once.
// - present count is readable at any time.
// - every clear after a cycle without clear captures the prior count into a readable field.
// - limit 1 to 4294967295 events ends counting.
// - counter state is readable.
// - start source is off, frame, exposure, acquisition or external.
// - edge start modes start on rising, falling or either edge.
// - level start modes hold the counter cleared while high or low.
// - edge-mode pulse lasts 1 to 134,217,727 microseconds.
// - output becomes active after 0 to 134,217,727 microseconds delay.
// - timer restart returns the timer to idle, ready again.
// - timer trigger is off, exposure, frame, external or counter start.
// - edge modes trigger the timer on rising or falling edge.
// - level modes keep output only while trigger level holds.
// - timer detects trigger, counts delay, then drives output.
// - output line follows the timer when timer source selected.
// - external trigger pulses shorter than debounce time are ignored.
//
// Local design decisions: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module ectm_top
  import ectm_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp,
  input  wire logic        frame_readout_window,
  input  wire logic        row_time_window,
  input  wire logic        exposure_window,
  input  wire logic        acquisition_window,
  input  wire logic        host_link_trigger,
  input  wire logic        external_trigger_input,
  output var  logic        count_start_event,
  output var  logic        pulse_timer_output,
  output var  logic        output_line_drive
);
  import ectm_pkg::*;

  typedef struct packed {
    ectm_count_cfg_type ccfg;
    ectm_pulse_cfg_type pcfg;
    logic [31:0]        limit;
    logic [DLY_W-1:0]   delay;
    logic [DLY_W-1:0]   length;
    logic [DB_W-1:0]    dbt;
    ectm_cstate_type    cst;
    logic [31:0]        count;
    logic [31:0]        capt;
    logic               clr_held;
    logic               ev_p;
    logic               clr_p;
    logic               st_p;
    logic               tr_p;
    ectm_tstate_type    tst;
    logic [PRE_W-1:0]   pre;
    logic [DLY_W-1:0]   tcnt;
    logic               cstart_ev;
    logic               tout;
    logic               line;
    logic               dph_wr;
    logic               dph_rd;
    logic [ADDR_W-1:0]  dph_a;
    logic               hready;
    logic [31:0]        rdata;
    logic               resp;
  } ectm_state_type;

  localparam ectm_state_type ST_RESET = '{
    limit:   LIMIT_RST,
    length:  LEN_MIN,
    hready:  1'b1,
    cst:     C_IDLE,
    tst:     T_IDLE,
    default: '0
  };

  ectm_state_type     st, n;
  logic               ext_f;
  logic [7:0]         srcs;
  logic               evs, clrs, sts, trs;
  logic               clr_on, start_on, tr_on, tr_lvl;
  logic               ev_hit, clr_hw, start_lvl_clr, start_edge, tr_hit;
  logic               sw_clr, restart, clr_any, acc, tick;
  logic [31:0]        inc;
  logic [DLY_W-1:0]   tinc;
  logic [31:0]        rd;
  logic [CS_W-1:0]    cs_rd;
  ectm_count_cfg_type wcfg;
  ectm_pulse_cfg_type wpcfg;
  ectm_cmd_type       wcmd;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic edge_hit(input logic [2:0] cond, input logic cur,
                                    input logic prev);
    logic r;
    r = 1'b0;
    case (cond)
      COND_RISE: r = cur & ~prev;
      COND_FALL: r = ~cur & prev;
      COND_ANY:  r = cur ^ prev;
      COND_HIGH: r = cur;
      COND_LOW:  r = ~cur;
      default:   r = 1'b0;
    endcase
    return r;
  endfunction

  function automatic logic is_level(input logic [2:0] cond);
    return (cond == COND_HIGH) || (cond == COND_LOW);
  endfunction

  // ----------------------------------------------------------------
  // external trigger conditioning
  // ----------------------------------------------------------------
  ectm_debounce u_debounce (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .pin_in      (external_trigger_input),
    .debounce_us (st.dbt),
    .level_out   (ext_f)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    n = st;
    wcfg = ectm_count_cfg_type'(hwdata);
    wpcfg = ectm_pulse_cfg_type'(hwdata);
    wcmd = ectm_cmd_type'(hwdata);
    srcs = {st.cstart_ev, ext_f, host_link_trigger, acquisition_window,
            exposure_window, row_time_window, frame_readout_window, 1'b0};

    // source selection; codes outside a selector's subset act as off
    evs = EV_MASK[st.ccfg.ev_src] & srcs[st.ccfg.ev_src];
    clr_on = CLR_MASK[st.ccfg.clr_src];
    clrs = srcs[st.ccfg.clr_src];
    start_on = ST_MASK[st.ccfg.start_src];
    sts = srcs[st.ccfg.start_src];
    tr_on = TMR_MASK[st.pcfg.src];
    trs = srcs[st.pcfg.src];
    tr_lvl = is_level(st.pcfg.cond);
    n.ev_p = evs;
    n.clr_p = clrs;
    n.st_p = sts;
    n.tr_p = trs;

    ev_hit = EV_MASK[st.ccfg.ev_src] & (evs ^ st.ev_p) & (evs ^ st.ccfg.edge_fall);
    clr_hw = clr_on & edge_hit(st.ccfg.clr_cond, clrs, st.clr_p);
    start_lvl_clr = start_on & is_level(st.ccfg.start_cond)
                    & edge_hit(st.ccfg.start_cond, sts, st.st_p);
    start_edge = start_on & ~is_level(st.ccfg.start_cond)
                 & edge_hit(st.ccfg.start_cond, sts, st.st_p);
    tr_hit = tr_on & edge_hit(st.pcfg.cond, trs, st.tr_p);

    // bus data phase
    acc = hsel & hready & (htrans inside {HT_NONSEQ, HT_SEQ});
    sw_clr = st.dph_wr & (st.dph_a == A_CMD) & wcmd.count_clear;
    restart = st.dph_wr & (st.dph_a == A_CMD) & wcmd.timer_restart;
    if (st.dph_wr) begin
      case (st.dph_a)
        A_COUNT_CFG: begin
          // a write naming a missing instance is dropped whole
          if (!wcfg.inst) begin
            n.ccfg = wcfg;
            n.ccfg.rsv = '0;
          end
        end
        A_LIMIT: n.limit = (hwdata == '0) ? LIMIT_MIN : hwdata;
        A_PULSE_CFG: begin
          n.pcfg = wpcfg;
          n.pcfg.rsv = '0;
        end
        A_DELAY: n.delay = hwdata[DLY_W-1:0];
        A_LENGTH: begin
          n.length = (hwdata[DLY_W-1:0] == '0) ? LEN_MIN : hwdata[DLY_W-1:0];
        end
        A_DEBOUNCE: n.dbt = (hwdata > 32'(DB_MAX)) ? DB_MAX : hwdata[DB_W-1:0];
        default: ;
      endcase
    end

    // counter
    clr_any = sw_clr | clr_hw | start_lvl_clr;
    inc = st.count + 32'h1;
    n.cstart_ev = 1'b0;
    n.clr_held = clr_any;
    if (clr_any) begin
      // a held level clears every cycle; only its first cycle captures
      if (!st.clr_held) begin
        n.capt = st.count;
      end
      n.count = '0;
      if (sw_clr || !start_on || is_level(st.ccfg.start_cond)) begin
        n.cst = C_RUN;
      end else begin
        n.cst = C_IDLE;
      end
    end else begin
      case (st.cst)
        C_IDLE: begin
          if (!start_on || is_level(st.ccfg.start_cond) || start_edge) begin
            n.cst = C_RUN;
          end
        end
        C_RUN: begin
          if (st.count >= st.limit) begin
            n.cst = C_DONE;
          end else if (ev_hit) begin
            n.count = inc;
            if (inc >= st.limit) begin
              n.cst = C_DONE;
            end
          end
        end
        C_DONE: n.cst = C_DONE;
        default: n.cst = C_IDLE;
      endcase
    end
    n.cstart_ev = (n.cst == C_RUN) & (st.cst != C_RUN);

    // timer; prescaler restarts at the trigger so delays are exact
    tick = (st.pre == PRE_LAST);
    n.pre = tick ? '0 : st.pre + 6'h1;
    tinc = st.tcnt + 27'h1;
    case (st.tst)
      T_IDLE: begin
        if (tr_hit) begin
          n.pre = '0;
          n.tcnt = '0;
          n.tst = (st.delay == '0) ? T_PULSE : T_DELAY;
        end
      end
      T_DELAY: begin
        if (tr_lvl && !tr_hit) begin
          n.tst = T_IDLE;
        end else if (tick) begin
          n.tcnt = tinc;
          if (tinc >= st.delay) begin
            n.tcnt = '0;
            n.tst = T_PULSE;
          end
        end
      end
      T_PULSE: begin
        if (tr_lvl) begin
          if (!tr_hit) begin
            n.tst = T_IDLE;
          end
        end else if (tick) begin
          n.tcnt = tinc;
          if (tinc >= st.length) begin
            n.tst = T_IDLE;
          end
        end
      end
      default: n.tst = T_IDLE;
    endcase
    if (restart || !tr_on) begin
      n.tst = T_IDLE;
      n.tcnt = '0;
      n.pre = '0;
    end
    n.tout = (n.tst == T_PULSE);
    n.line = n.tout & n.pcfg.line_timer;

    // register read: one wait state so a write just before is seen
    cs_rd = (st.ccfg.ev_src == SRC_OFF) ? CS_IDLE : st.cst;
    rd = '0;
    case (st.dph_a)
      A_COUNT_CFG: rd = st.ccfg;
      A_NOW:       rd = st.count;
      A_CAPT:      rd = st.capt;
      A_LIMIT:     rd = st.limit;
      A_STATE:     rd[CS_W-1:0] = cs_rd;
      A_PULSE_CFG: rd = st.pcfg;
      A_DELAY:     rd[DLY_W-1:0] = st.delay;
      A_LENGTH:    rd[DLY_W-1:0] = st.length;
      A_DEBOUNCE:  rd[DB_W-1:0] = st.dbt;
      default:     rd = '0;
    endcase
    if (st.dph_rd) begin
      n.rdata = rd;
    end
    n.dph_wr = acc & hwrite;
    n.dph_rd = acc & ~hwrite;
    if (acc) begin
      n.dph_a = haddr[ADDR_W-1:0];
    end
    n.hready = ~(acc & ~hwrite);
    n.resp = 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= ST_RESET;
    end else begin
      st <= n;
    end
  end

  assign hrdata = st.rdata;
  assign hreadyout = st.hready;
  assign hresp = st.resp;
  assign count_start_event = st.cstart_ev;
  assign pulse_timer_output = st.tout;
  assign output_line_drive = st.line;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_CNT_STEP: assert property (@(posedge hclk) disable iff (!hresetn)
    (st.cst == C_RUN && ev_hit && !clr_any && st.count < st.limit)
      |=> (st.count == $past(st.count) + 32'h1))
    else $error("counter did not step by one");

  AST_CNT_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
    (st.cst == C_DONE && !clr_any) |=> ($stable(st.count) && st.cst == C_DONE))
    else $error("counter moved after reaching its limit");

  AST_CAPTURE: assert property (@(posedge hclk) disable iff (!hresetn)
    (clr_any && !st.clr_held) |=> (st.capt == $past(st.count) && st.count == '0))
    else $error("clear did not capture the prior count");

  AST_SW_RESUME: assert property (@(posedge hclk) disable iff (!hresetn)
    sw_clr |=> (st.cst == C_RUN && st.count == '0))
    else $error("software clear did not resume counting");

  AST_LVL_CLR: assert property (@(posedge hclk) disable iff (!hresetn)
    (clr_on && st.ccfg.clr_cond == COND_HIGH && clrs)[*2] |=> (st.count == '0))
    else $error("count not held cleared by level");

  AST_OFF_HALT: assert property (@(posedge hclk) disable iff (!hresetn)
    (st.ccfg.ev_src == SRC_OFF && !clr_any) |=> $stable(st.count))
    else $error("counter advanced with source off");

  AST_ZERO_DLY: assert property (@(posedge hclk) disable iff (!hresetn)
    (st.tst == T_IDLE && tr_hit && st.delay == '0 && !restart) |=> pulse_timer_output)
    else $error("zero delay did not start the pulse at once");

  AST_LVL_DROP: assert property (@(posedge hclk) disable iff (!hresetn)
    (st.tst == T_PULSE && tr_lvl && !tr_hit) |=> !pulse_timer_output)
    else $error("timer output outlived its trigger level");

  AST_RESTART: assert property (@(posedge hclk) disable iff (!hresetn)
    restart |=> (st.tst == T_IDLE && !pulse_timer_output))
    else $error("timer restart did not return to idle");

  AST_LINE: assert property (@(posedge hclk) disable iff (!hresetn)
    output_line_drive |-> (pulse_timer_output && st.pcfg.line_timer))
    else $error("output line driven without the timer");

  AST_RD_WAIT: assert property (@(posedge hclk) disable iff (!hresetn)
    (acc && !hwrite) |=> !hreadyout ##1 hreadyout)
    else $error("read did not take exactly one wait state");

  COV_DONE: cover property (@(posedge hclk) disable iff (!hresetn)
    st.cst == C_RUN ##1 st.cst == C_DONE);
  COV_PULSE: cover property (@(posedge hclk) disable iff (!hresetn)
    st.tst == T_DELAY ##1 st.tst == T_PULSE);
  COV_CAPT: cover property (@(posedge hclk) disable iff (!hresetn)
    clr_any && st.count != '0);

endmodule
`default_nettype wire

/* File: shared/ectm_pkg.sv */
package ectm_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS       = 25;
  localparam int US_NS        = 1000;
  localparam int TICKS_PER_US = US_NS / CLK_NS;
  localparam int PRE_W        = 6;
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICKS_PER_US - 1);

  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DLY_W  = 27;
  localparam int DB_W   = 20;
  localparam int CS_W   = 2;
  localparam logic [31:0]      LIMIT_RST = 32'hFFFFFFFF;
  localparam logic [31:0]      LIMIT_MIN = 32'h1;
  localparam logic [DLY_W-1:0] LEN_MIN   = 27'h1;
  localparam logic [DB_W-1:0]  DB_MAX    = 20'hF4240;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] A_COUNT_CFG = 8'h00;
  localparam logic [ADDR_W-1:0] A_CMD       = 8'h04;
  localparam logic [ADDR_W-1:0] A_NOW       = 8'h08;
  localparam logic [ADDR_W-1:0] A_CAPT      = 8'h0C;
  localparam logic [ADDR_W-1:0] A_LIMIT     = 8'h10;
  localparam logic [ADDR_W-1:0] A_STATE     = 8'h14;
  localparam logic [ADDR_W-1:0] A_PULSE_CFG = 8'h18;
  localparam logic [ADDR_W-1:0] A_DELAY     = 8'h1C;
  localparam logic [ADDR_W-1:0] A_LENGTH    = 8'h20;
  localparam logic [ADDR_W-1:0] A_DEBOUNCE  = 8'h24;

  localparam logic [1:0] HT_NONSEQ = 2'h2;
  localparam logic [1:0] HT_SEQ    = 2'h3;

  // ----------------------------------------------------------------
  // source codes: one set, each selector accepts a subset
  // ----------------------------------------------------------------
  localparam logic [2:0] SRC_OFF = 3'h0;
  localparam logic [2:0] SRC_FRAME = 3'h1;
  localparam logic [2:0] SRC_ROW = 3'h2;
  localparam logic [2:0] SRC_EXPO = 3'h3;
  localparam logic [2:0] SRC_ACQ = 3'h4;
  localparam logic [2:0] SRC_LINK = 3'h5;
  localparam logic [2:0] SRC_EXT = 3'h6;
  localparam logic [2:0] SRC_CSTART = 3'h7;
  localparam logic [7:0] EV_MASK  = 8'h6E;
  localparam logic [7:0] CLR_MASK = 8'h5A;
  localparam logic [7:0] ST_MASK  = 8'h5A;
  localparam logic [7:0] TMR_MASK = 8'hCA;

  localparam logic [2:0] COND_RISE = 3'h0;
  localparam logic [2:0] COND_FALL = 3'h1;
  localparam logic [2:0] COND_ANY  = 3'h2;
  localparam logic [2:0] COND_HIGH = 3'h3;
  localparam logic [2:0] COND_LOW  = 3'h4;

  localparam logic [CS_W-1:0] CS_IDLE = 2'h0;

  // ----------------------------------------------------------------
  // field layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [14:0] rsv;
    logic        inst;
    logic [2:0]  start_cond;
    logic [2:0]  start_src;
    logic [2:0]  clr_cond;
    logic [2:0]  clr_src;
    logic        edge_fall;
    logic [2:0]  ev_src;
  } ectm_count_cfg_type;

  typedef struct packed {
    logic [24:0] rsv;
    logic        line_timer;
    logic [2:0]  cond;
    logic [2:0]  src;
  } ectm_pulse_cfg_type;

  typedef struct packed {
    logic [29:0] rsv;
    logic        timer_restart;
    logic        count_clear;
  } ectm_cmd_type;

  typedef enum logic [CS_W-1:0] {C_IDLE, C_RUN, C_DONE} ectm_cstate_type;
  typedef enum logic [1:0] {T_IDLE, T_DELAY, T_PULSE} ectm_tstate_type;

endpackage

/* File: rtl/ectm_debounce.sv */
`timescale 1ns/1ps
`default_nettype none
module ectm_debounce
  import ectm_pkg::*;
(
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  input  wire logic                      pin_in,
  input  wire logic [ectm_pkg::DB_W-1:0] debounce_us,
  output var  logic                      level_out
);
  import ectm_pkg::*;

  typedef struct packed {
    logic             s1;
    logic             s2;
    logic             stable;
    logic [PRE_W-1:0] pre;
    logic [DB_W-1:0]  cnt;
  } ectm_db_type;

  ectm_db_type st, n;

  // ----------------------------------------------------------------
  // filter
  // ----------------------------------------------------------------
  always_comb begin
    n = st;
    n.s1 = pin_in;
    n.s2 = st.s1;
    // time restarts at every bounce, so a glitch never accumulates
    if (st.s2 == st.stable) begin
      n.cnt = '0;
      n.pre = '0;
    end else if (st.cnt >= debounce_us) begin
      n.stable = st.s2;
      n.cnt = '0;
      n.pre = '0;
    end else if (st.pre == PRE_LAST) begin
      n.pre = '0;
      n.cnt = st.cnt + 20'h1;
    end else begin
      n.pre = st.pre + 6'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else begin
      st <= n;
    end
  end

  assign level_out = st.stable;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_DB_FILTER: assert property (@(posedge hclk) disable iff (!hresetn)
    (st.stable != $past(st.stable)) |-> ($past(st.cnt) >= $past(debounce_us)))
    else $error("debounced level changed before the hold time");

endmodule
`default_nettype wire

/* File: test/ectm_cam_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ectm_cam_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [5:0] req,
  output var  logic       frame_readout_window,
  output var  logic       row_time_window,
  output var  logic       exposure_window,
  output var  logic       acquisition_window,
  output var  logic       host_link_trigger,
  output var  logic       external_trigger_input
);
  // camera levels change only on the clock, as the block assumes same-clock sources
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {external_trigger_input, host_link_trigger, acquisition_window} <= 3'h0;
      {exposure_window, row_time_window, frame_readout_window} <= 3'h0;
    end else begin
      {external_trigger_input, host_link_trigger, acquisition_window} <= req[5:3];
      {exposure_window, row_time_window, frame_readout_window} <= req[2:0];
    end
  end
endmodule
`default_nettype wire

/* File: test/event_counter_and_pulse_timer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module event_counter_and_pulse_timer_tb;
  import ectm_pkg::*;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic [1:0] htrans = 2'h0;
  logic [5:0] req = 6'h0;
  wire logic [31:0] hrdata;
  wire logic hreadyout, hresp, fr, rw, ex, aq, lk, et, cse, tout, lout;
  int n_fail = 0, cmp_count = 0, n, i;
  int cse_seen = 0;
  logic [2:0] srcs [5] = '{SRC_FRAME, SRC_ROW, SRC_EXPO, SRC_LINK, SRC_EXT};
  int bits [5] = '{0, 1, 2, 4, 5};
  always #12.5 hclk = ~hclk;
  // start pulses stand one cycle, so count them as they pass
  always @(posedge hclk) cse_seen <= cse_seen + int'(cse === 1'b1);
  ectm_cam_model cam_u (.hclk(hclk), .hresetn(hresetn), .req(req),
    .frame_readout_window(fr), .row_time_window(rw), .exposure_window(ex),
    .acquisition_window(aq), .host_link_trigger(lk), .external_trigger_input(et));
  ectm_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .frame_readout_window(fr), .row_time_window(rw), .exposure_window(ex),
    .acquisition_window(aq), .host_link_trigger(lk), .external_trigger_input(et),
    .count_start_event(cse), .pulse_timer_output(tout), .output_line_drive(lout));
  // ----------------------------------------------------------------
  // checks and closing
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk_val(input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // timing check with a small window for edge detect and register latency
  task automatic chk_near(input int e, input int g, input int tol);
    cmp_count++;
    if (g < e - tol || g > e + tol) begin
      n_fail++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic wait_ready();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1) begin
      n_fail++;
      end_sim();
    end
  endtask
  // ----------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= HT_NONSEQ;
    wait_ready();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
    chk_val(32'h0, {31'h0, hresp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk_val(e, rd);
  endtask
  task automatic pulse(input int b, input int cnt);
    repeat (cnt) begin
      @(posedge hclk) req[b] <= 1'b1;
      repeat (6) @(posedge hclk);
      req[b] <= 1'b0;
      repeat (6) @(posedge hclk);
    end
  endtask
  task automatic wait_out(input logic v, output int c);
    c = 0;
    while (tout !== v && c < 5000) begin
      @(posedge hclk);
      c++;
    end
    if (tout !== v) begin
      n_fail++;
      end_sim();
    end
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rchk(A_LIMIT, LIMIT_RST);
    rchk(A_LENGTH, 32'h1);
    rchk(A_STATE, 32'h0);
    wr(8'h28, 32'h5);
    rchk(8'h28, 32'h0);
    wr(A_COUNT_CFG, 32'h10001);
    rchk(A_COUNT_CFG, 32'h0);
    $display("test reset and map done");
    for (i = 0; i < 5; i++) begin
      wr(A_COUNT_CFG, {28'h0, i[0], srcs[i]});
      wr(A_CMD, 32'h1);
      pulse(bits[i], 2);
      rchk(A_NOW, 32'h2);
    end
    $display("test event sources done");
    wr(A_COUNT_CFG, 32'h1);
    wr(A_LIMIT, 32'h4);
    wr(A_CMD, 32'h1);
    pulse(0, 1);
    rchk(A_STATE, 32'h1);
    pulse(0, 5);
    rchk(A_NOW, 32'h4);
    rchk(A_STATE, 32'h2);
    wr(A_CMD, 32'h1);
    rchk(A_CAPT, 32'h4);
    rchk(A_NOW, 32'h0);
    rchk(A_STATE, 32'h1);
    $display("test limit and clear done");
    wr(A_LIMIT, LIMIT_RST);
    wr(A_COUNT_CFG, {22'h0, COND_HIGH, SRC_EXPO, 1'b0, SRC_FRAME});
    pulse(0, 3);
    @(posedge hclk) req[2] <= 1'b1;
    pulse(0, 1);
    rchk(A_NOW, 32'h0);
    rchk(A_CAPT, 32'h3);
    @(posedge hclk) req[2] <= 1'b0;
    $display("test level clear done");
    wr(A_DELAY, 32'h1);
    wr(A_LENGTH, 32'h2);
    wr(A_PULSE_CFG, {25'h0, 1'b1, COND_RISE, SRC_EXPO});
    @(posedge hclk) req[2] <= 1'b1;
    wait_out(1'b1, n);
    chk_near(42, n, 3);
    chk_val(32'h1, {31'h0, lout});
    wait_out(1'b0, n);
    chk_near(80, n, 2);
    req[2] <= 1'b0;
    $display("test edge timer done");
    wr(A_PULSE_CFG, {25'h0, 1'b0, COND_HIGH, SRC_EXPO});
    @(posedge hclk) req[2] <= 1'b1;
    wait_out(1'b1, n);
    chk_near(42, n, 3);
    repeat (100) @(posedge hclk);
    req[2] <= 1'b0;
    wait_out(1'b0, n);
    chk_near(2, n, 2);
    $display("test level timer done");
    wr(A_LENGTH, 32'h64);
    wr(A_PULSE_CFG, {25'h0, 1'b1, COND_FALL, SRC_EXPO});
    pulse(2, 1);
    wait_out(1'b1, n);
    wr(A_CMD, 32'h2);
    repeat (2) @(posedge hclk);
    chk_val(32'h0, {30'h0, tout, lout});
    $display("test timer restart done");
    wr(A_DEBOUNCE, 32'hFFFFFFFF);
    rchk(A_DEBOUNCE, 32'h000F4240);
    wr(A_DEBOUNCE, 32'h1);
    wr(A_COUNT_CFG, {29'h0, SRC_EXT});
    wr(A_CMD, 32'h1);
    pulse(5, 1);
    @(posedge hclk) req[5] <= 1'b1;
    repeat (100) @(posedge hclk);
    req[5] <= 1'b0;
    repeat (100) @(posedge hclk);
    rchk(A_NOW, 32'h1);
    $display("test debounce done");
    wr(A_LENGTH, 32'h1);
    wr(A_DELAY, 32'h0);
    wr(A_PULSE_CFG, {25'h0, 1'b0, COND_RISE, SRC_CSTART});
    wr(A_COUNT_CFG, {16'h0, COND_RISE, SRC_ACQ, COND_RISE, SRC_EXPO, 1'b0, SRC_FRAME});
    pulse(2, 1);
    pulse(0, 2);
    rchk(A_CAPT, 32'h1);
    rchk(A_NOW, 32'h0);
    rchk(A_STATE, 32'h0);
    i = cse_seen;
    @(posedge hclk) req[3] <= 1'b1;
    wait_out(1'b1, n);
    chk_near(4, n, 2);
    chk_val(i + 1, cse_seen);
    pulse(0, 3);
    rchk(A_NOW, 32'h3);
    req[3] <= 1'b0;
    $display("test start trigger done");
    end_sim();
  end
endmodule
`default_nettype wire
